// ==== sim/clhp_host_model.sv ====
// Host processor model driving the parallel port
`timescale 1ns/1ps
module clhp_host_model (
  input wire logic clk_in,
  input wire logic m4_in,
  input wire logic [7:0] bus_in,
  output logic rs_out = 1'b0,
  output logic rw_out = 1'b1,
  output logic strobe_out = 1'b0,
  output logic [7:0] drv_out = 8'h00,
  output logic [7:0] drv_en_out = 8'h00
);
  // One strobe cycle, 40 ns per phase
  task automatic cyc(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    rs_out <= rs;
    rw_out <= rw;
    drv_out <= d;
    drv_en_out <= rw ? 8'h00 : (m4_in ? 8'hF0 : 8'hFF);
    repeat (8) @(posedge clk_in);
    strobe_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    q = bus_in;
    strobe_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    drv_en_out <= 8'h00;
  endtask
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (m4_in) begin
      cyc(rs, rw, {d[7:4], 4'h0}, a);
      cyc(rs, rw, {d[3:0], 4'h0}, b);
      q = {a[7:4], b[7:4]};
    end else begin
      cyc(rs, rw, d, q);
    end
  endtask
  task automatic wait_idle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = !s[7];
    end
  endtask
endmodule

// ==== sim/clhp_host_port_chk.sv ====
// Pin-level assertions for the host port
`timescale 1ns/1ps
module clhp_host_port_chk #(
  parameter int OP_CYCLES = 8
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic REGISTER_SELECT_LINE_IN,
  input wire logic RW_IN,
  input wire logic STROBE_IN,
  input wire logic BUS_4BIT_IN,
  input wire logic [7:0] BIDIR_BUS_LINES_OUT,
  input wire logic [7:0] BIDIR_BUS_LINES_OE_N_OUT,
  input wire logic [7:0] INSTRUCTION_HOLDING_OUT,
  input wire logic INSTR_STB_OUT,
  input wire logic BUSY_FLAG_OUT,
  input wire logic [6:0] RAM_POINTER_OUT
);
  localparam int BUSY_MAX = OP_CYCLES + 2;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  sequence s_wr;
    (STROBE_IN && !RW_IN && !BUSY_FLAG_OUT && !BUS_4BIT_IN)[*5] ##1 !STROBE_IN;
  endsequence
  property p_wr_busy;
    s_wr |-> ##[1:5] BUSY_FLAG_OUT;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write not taken");
  property p_rd;
    (STROBE_IN && RW_IN)[*5] |-> !BIDIR_BUS_LINES_OE_N_OUT[7];
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_rel;
    (!STROBE_IN || !RW_IN)[*5] |-> BIDIR_BUS_LINES_OE_N_OUT == 8'hFF;
  endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_nib;
    BUS_4BIT_IN[*5] |-> BIDIR_BUS_LINES_OE_N_OUT[3:0] == 4'hF;
  endproperty
  a_nib: assert property (p_nib) else $error("low lines driven");
  property p_stat;
    (!REGISTER_SELECT_LINE_IN && RW_IN && STROBE_IN && !BUS_4BIT_IN && $stable(BUSY_FLAG_OUT)
      && $stable(RAM_POINTER_OUT))[*5] |-> BIDIR_BUS_LINES_OUT == {BUSY_FLAG_OUT, RAM_POINTER_OUT};
  endproperty
  a_stat: assert property (p_stat) else $error("status wrong");
  property p_stb;
    INSTR_STB_OUT |-> BUSY_FLAG_OUT ##1 !INSTR_STB_OUT;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe pulse wrong");
  property p_bmax;
    $rose(BUSY_FLAG_OUT) |-> ##[1:BUSY_MAX] !BUSY_FLAG_OUT;
  endproperty
  a_bmax: assert property (p_bmax) else $error("busy too long");
  property p_hold;
    BUSY_FLAG_OUT && $past(BUSY_FLAG_OUT) |-> $stable(INSTRUCTION_HOLDING_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("taken while busy");
endmodule

// ==== sim/clhp_host_port_tb_top.sv ====
// Self-checking bench for the host port
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module clhp_host_port_tb_top;
  typedef struct packed {logic m4; logic up; logic rs; logic rw; logic [7:0] d;} clhp_row_s;
  // Mode, entry up, select, read, byte written or expected
  localparam clhp_row_s ROWS [23] = '{12'h485, 12'h6A5, 12'h63C, 12'h507, 12'h485, 12'h7A5, 12'h73C,
    12'h086, 12'h33C, 12'h105, 12'h47F, 12'h611, 12'h500, 12'h47F, 12'h711, 12'hC85, 12'hFA5,
    12'hD06, 12'h4CF, 12'h65A, 12'h550, 12'h4D0, 12'h700};
  logic clk, srst, m4, up, rs, rw, stb, istb, busy, glyph, ok;
  logic [7:0] bus, dout, oe_n, hdrv, hen, pat, instr, q;
  logic [6:0] ptr;
  int failures, check_count, cyc_n, stb_n, base;
  assign bus = (~oe_n & dout) | (oe_n & ((hen & hdrv) | (~hen & pat)));
  clhp_host_port #(.OP_CYCLES(80)) i_dut (.CLK_IN(clk), .SRST_IN(srst), .REGISTER_SELECT_LINE_IN(rs),
    .RW_IN(rw), .STROBE_IN(stb), .BIDIR_BUS_LINES_IN(bus), .BIDIR_BUS_LINES_OUT(dout),
    .BIDIR_BUS_LINES_OE_N_OUT(oe_n), .BUS_4BIT_IN(m4), .ENTRY_UP_IN(up), .INSTRUCTION_HOLDING_OUT(instr),
    .INSTR_STB_OUT(istb), .BUSY_FLAG_OUT(busy), .RAM_POINTER_OUT(ptr), .GLYPH_SEL_OUT(glyph));
  clhp_host_model i_host (.clk_in(clk), .m4_in(m4), .bus_in(bus), .rs_out(rs), .rw_out(rw),
    .strobe_out(stb), .drv_out(hdrv), .drv_en_out(hen));
  task automatic complete_run();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    pat <= ~pat;
    cyc_n <= cyc_n + 1;
    if (istb === 1'b1) stb_n <= stb_n + 1;
    if (cyc_n == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    m4 = 1'b0;
    up = 1'b1;
    pat = 8'h5A;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    `CHK({oe_n, dout, instr, busy, ptr, glyph}, {8'hFF, 8'h00, 8'h00, 1'b0, 7'h00, 1'b0})
    $display("reset done");
    foreach (ROWS[i]) begin
      m4 <= ROWS[i].m4;
      up <= ROWS[i].up;
      @(posedge clk);
      i_host.xfer(ROWS[i].rs, ROWS[i].rw, ROWS[i].d, q);
      if (ROWS[i].rw) `CHK(q, ROWS[i].d)
      i_host.wait_idle(ok);
      `CHK(ok, 1'b1)
    end
    $display("row table done");
    i_host.xfer(1'b0, 1'b0, 8'h40, q);
    i_host.wait_idle(ok);
    `CHK({glyph, ptr}, 8'h80)
    i_host.xfer(1'b0, 1'b0, 8'h80, q);
    i_host.wait_idle(ok);
    `CHK({glyph, ptr}, 8'h00)
    $display("memory select done");
    base = stb_n;
    i_host.xfer(1'b0, 1'b0, 8'h01, q);
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHK(q, 8'h80)
    i_host.xfer(1'b0, 1'b0, 8'h02, q);
    i_host.wait_idle(ok);
    `CHK(instr, 8'h01)
    `CHK(stb_n - base, 1)
    $display("busy refusal done");
    complete_run();
  end
endmodule
bind clhp_host_port clhp_host_port_chk #(.OP_CYCLES(OP_CYCLES)) i_chk (.*);

// ==== src/clhp_host_port.sv ====
// Host parallel port of a character display controller
`timescale 1ns/1ps
module clhp_host_port #(
  parameter int OP_CYCLES = clhp_pkg::OP_CYCLES,
  parameter int DISP_DEPTH = clhp_pkg::DISP_DEPTH,
  parameter int GLYPH_DEPTH = clhp_pkg::GLYPH_DEPTH
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic REGISTER_SELECT_LINE_IN,
  input wire logic RW_IN,
  input wire logic STROBE_IN,
  input wire logic [7:0] BIDIR_BUS_LINES_IN,
  output logic [7:0] BIDIR_BUS_LINES_OUT,
  output logic [7:0] BIDIR_BUS_LINES_OE_N_OUT,
  input wire logic BUS_4BIT_IN,
  input wire logic ENTRY_UP_IN,
  output logic [7:0] INSTRUCTION_HOLDING_OUT,
  output logic INSTR_STB_OUT,
  output logic BUSY_FLAG_OUT,
  output logic [6:0] RAM_POINTER_OUT,
  output logic GLYPH_SEL_OUT
);
  localparam int SYNC_W = 11;
  localparam int CNT_W = $clog2(OP_CYCLES + 1);
  localparam logic [CNT_W-1:0] OP_LOAD = CNT_W'(OP_CYCLES - 1);

  // Synchronised pins
  logic [SYNC_W-1:0] pins_s;
  logic rs_s;
  logic rw_s;
  logic strobe_s;
  logic [7:0] bus_s;

  // One-sample-old copies, aligned with the last strobe-high sample
  logic rs_d;
  logic rw_d;
  logic strobe_d;
  logic [7:0] bus_d;

  // Host-visible registers and internal state
  logic [7:0] instruction_holding;
  logic [7:0] data_holding;
  logic [6:0] ram_pointer;
  logic glyph_sel;
  logic busy_flag;
  clhp_pkg::clhp_state_e state;
  logic [CNT_W-1:0] op_cnt;
  logic nib_low;
  logic [3:0] hi_hold;

  // Memories
  logic [7:0] disp_mem [DISP_DEPTH];
  logic [7:0] glyph_mem [GLYPH_DEPTH];

  // Decoded events
  logic strobe_fall;
  logic byte_done;
  logic [7:0] wr_byte;
  logic instr_wr;
  logic data_wr;
  logic data_rd_done;
  logic is_set_disp;
  logic is_set_glyph;
  logic [6:0] next_pointer;
  logic [7:0] mem_rd_byte;
  logic [7:0] rd_byte;
  logic [7:0] next_bus_out;
  logic drive_bus;

  clhp_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .async_in({REGISTER_SELECT_LINE_IN, RW_IN, STROBE_IN, BIDIR_BUS_LINES_IN}),
    .sync_out(pins_s)
  );

  assign rs_s = pins_s[10];
  assign rw_s = pins_s[9];
  assign strobe_s = pins_s[8];
  assign bus_s = pins_s[7:0];

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rs_d <= 1'b0;
      rw_d <= 1'b0;
      strobe_d <= 1'b0;
      bus_d <= 8'h00;
    end else begin
      rs_d <= rs_s;
      rw_d <= rw_s;
      strobe_d <= strobe_s;
      bus_d <= bus_s;
    end
  end

  // Falling edge of the strobe ends one bus cycle
  assign strobe_fall = strobe_d & ~strobe_s;

  // In 4-bit mode a byte ends on the second strobe
  assign byte_done = ~BUS_4BIT_IN | nib_low;

  // Assemble the written byte
  always_comb begin
    if (BUS_4BIT_IN) begin
      wr_byte = {hi_hold, bus_d[7:4]};
    end else begin
      wr_byte = bus_d;
    end
  end

  assign busy_flag = (state != clhp_pkg::ST_IDLE);

  // Writes and reads are refused while busy; status reads are not
  assign instr_wr = strobe_fall & byte_done & ~rw_d & ~rs_d & ~busy_flag;
  assign data_wr = strobe_fall & byte_done & ~rw_d & rs_d & ~busy_flag;
  assign data_rd_done = strobe_fall & byte_done & rw_d & rs_d & ~busy_flag;

  // Address-setting instruction decode
  assign is_set_disp = wr_byte[clhp_pkg::SET_DISP_BIT];
  assign is_set_glyph = ~wr_byte[clhp_pkg::SET_DISP_BIT]
    & (wr_byte[clhp_pkg::SET_GLYPH_MSB:clhp_pkg::SET_GLYPH_LSB] == clhp_pkg::SET_GLYPH_TAG);

  // Pointer step, wrapped to the 64 glyph entries; the display pointer wraps at 7 bits
  always_comb begin
    next_pointer = ram_pointer;
    if (ENTRY_UP_IN) begin
      next_pointer = ram_pointer + 7'h01;
    end else begin
      next_pointer = ram_pointer - 7'h01;
    end
    if (glyph_sel) begin
      next_pointer[6] = 1'b0;
    end
  end

  // Nibble phase tracking
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      nib_low <= 1'b0;
      hi_hold <= 4'h0;
    end else if (!BUS_4BIT_IN) begin
      nib_low <= 1'b0;
    end else if (strobe_fall) begin
      nib_low <= ~nib_low;
      if (!nib_low) begin
        hi_hold <= bus_d[7:4];
      end
    end
  end

  // Instruction holding register, write-only to the host
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      instruction_holding <= clhp_pkg::INSTR_RESET;
      INSTR_STB_OUT <= 1'b0;
    end else begin
      INSTR_STB_OUT <= instr_wr;
      if (instr_wr) begin
        instruction_holding <= wr_byte;
      end
    end
  end

  // Internal operation sequencer
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state <= clhp_pkg::ST_IDLE;
      op_cnt <= '0;
    end else begin
      case (state)
        clhp_pkg::ST_IDLE: begin
          if (instr_wr) begin
            if (is_set_disp || is_set_glyph) begin
              state <= clhp_pkg::ST_FETCH;
            end else begin
              state <= clhp_pkg::ST_EXEC;
              op_cnt <= OP_LOAD;
            end
          end else if (data_wr) begin
            state <= clhp_pkg::ST_WRITE;
          end else if (data_rd_done) begin
            state <= clhp_pkg::ST_FETCH;
          end
        end
        clhp_pkg::ST_WRITE: begin
          state <= clhp_pkg::ST_IDLE;
        end
        clhp_pkg::ST_FETCH: begin
          state <= clhp_pkg::ST_IDLE;
        end
        clhp_pkg::ST_EXEC: begin
          if (op_cnt == '0) begin
            state <= clhp_pkg::ST_IDLE;
          end else begin
            op_cnt <= op_cnt - CNT_W'(1);
          end
        end
        default: begin
          state <= clhp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address counter and memory select
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ram_pointer <= clhp_pkg::AC_RESET;
      glyph_sel <= 1'b0;
    end else if (instr_wr && is_set_disp) begin
      ram_pointer <= wr_byte[6:0];
      glyph_sel <= 1'b0;
    end else if (instr_wr && is_set_glyph) begin
      ram_pointer <= {1'b0, wr_byte[5:0]};
      glyph_sel <= 1'b1;
    end else if (data_rd_done || state == clhp_pkg::ST_WRITE) begin
      ram_pointer <= next_pointer;
    end
  end

  // Memory read at the pointer; display addresses past the end read zero
  always_comb begin
    mem_rd_byte = 8'h00;
    if (glyph_sel) begin
      mem_rd_byte = glyph_mem[ram_pointer[clhp_pkg::GLYPH_AW-1:0]];
    end else if (int'(ram_pointer) < DISP_DEPTH) begin
      mem_rd_byte = disp_mem[ram_pointer];
    end
  end

  // Memory writes from the data holding register
  always_ff @(posedge CLK_IN) begin
    if (state == clhp_pkg::ST_WRITE) begin
      if (glyph_sel) begin
        glyph_mem[ram_pointer[clhp_pkg::GLYPH_AW-1:0]] <= data_holding;
      end else if (int'(ram_pointer) < DISP_DEPTH) begin
        disp_mem[ram_pointer] <= data_holding;
      end
    end
  end

  // Data holding register
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      data_holding <= clhp_pkg::DATA_RESET;
    end else if (data_wr) begin
      data_holding <= wr_byte;
    end else if (state == clhp_pkg::ST_FETCH) begin
      data_holding <= mem_rd_byte;
    end
  end

  // Read byte: status when RS low, data when RS high
  always_comb begin
    if (rs_s) begin
      rd_byte = data_holding;
    end else begin
      rd_byte = {busy_flag, ram_pointer};
    end
  end

  // Place the read byte on the lines for the current bus width
  always_comb begin
    next_bus_out = rd_byte;
    if (BUS_4BIT_IN) begin
      next_bus_out[3:0] = 4'h0;
      if (nib_low) begin
        next_bus_out[7:4] = rd_byte[3:0];
      end
    end
  end

  assign drive_bus = rw_s & strobe_s;

  // Bus output and enables
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      BIDIR_BUS_LINES_OUT <= 8'h00;
      BIDIR_BUS_LINES_OE_N_OUT <= 8'hFF;
    end else begin
      BIDIR_BUS_LINES_OUT <= next_bus_out;
      if (!drive_bus) begin
        BIDIR_BUS_LINES_OE_N_OUT <= 8'hFF;
      end else if (BUS_4BIT_IN) begin
        BIDIR_BUS_LINES_OE_N_OUT <= 8'h0F;
      end else begin
        BIDIR_BUS_LINES_OE_N_OUT <= 8'h00;
      end
    end
  end

  assign INSTRUCTION_HOLDING_OUT = instruction_holding;
  assign BUSY_FLAG_OUT = busy_flag;
  assign RAM_POINTER_OUT = ram_pointer;
  assign GLYPH_SEL_OUT = glyph_sel;
endmodule

// ==== src/clhp_pkg.sv ====
// Shared constants and types for the character display host port
package clhp_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int AC_W = 7;
  localparam int GLYPH_AW = 6;
  localparam int DISP_DEPTH = 80;
  localparam int GLYPH_DEPTH = 64;
  localparam int BUSY_BIT = 7;
  localparam int NIB_HI_LSB = 4;
  localparam int SET_DISP_BIT = 7;
  localparam int SET_GLYPH_MSB = 7;
  localparam int SET_GLYPH_LSB = 6;
  localparam logic [1:0] SET_GLYPH_TAG = 2'h1;
  localparam logic [7:0] INSTR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OP_TIME_NS = 40;
  localparam int OP_CYCLES = (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_FETCH = 2'h2,
    ST_EXEC = 2'h3
  } clhp_state_e;
endpackage

// ==== src/clhp_sync.sv ====
// Two-stage synchroniser for signals entering the clock domain
`timescale 1ns/1ps
module clhp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== src/clhp_unused_note.sv ====
// Holds no logic of its own
